//--- include/ppcb_pkg.sv
// package of constants for the port pin configuration bank
package ppcb_pkg;
    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int unsigned NREG = 8;         // registers in the bank
    localparam int unsigned NSLOT = 7;        // ports 0,1,3,4,6,7,8
    localparam int unsigned NPIN = 56;        // eight pins per slot
    // ----------------------------------------------------------------
    // slot numbers of the ports on the flat pin vectors
    // ----------------------------------------------------------------
    localparam int unsigned SLOT_P0 = 0;
    localparam int unsigned SLOT_P1 = 1;
    localparam int unsigned SLOT_P3 = 2;
    localparam int unsigned SLOT_P4 = 3;
    localparam int unsigned SLOT_P6 = 4;
    localparam int unsigned SLOT_P7 = 5;
    localparam int unsigned SLOT_P8 = 6;
    // ----------------------------------------------------------------
    // register indices, byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [9:0] REG_IDX [NREG] = '{
        10'h18F, 10'h1E0, 10'h1E1, 10'h1E2,
        10'h1F0, 10'h1F2, 10'h1F3, 10'h1F4};
    localparam int unsigned R_MISC = 0;       // pin_function_misc
    localparam int unsigned R_PULLUP_CONTROL_0 = 1;       // pullup_control_0
    localparam int unsigned R_PULLUP_CONTROL_1 = 2;       // pullup_control_1
    localparam int unsigned R_PULLUP_CONTROL_2 = 3;       // pullup_control_2
    localparam int unsigned R_P1DRV = 4;      // port1_drive_strength
    localparam int unsigned R_DRV0 = 5;       // drive_strength_0
    localparam int unsigned R_DRV1 = 6;       // drive_strength_1
    localparam int unsigned R_DRV2 = 7;       // drive_strength_2
    // implemented bits; all others read zero and drop writes
    localparam logic [7:0] REG_MASK [NREG] = '{
        8'hF8, 8'hCF, 8'hA2, 8'h01, 8'hFF, 8'hC3, 8'hA2, 8'h01};
    localparam logic [7:0] REG_RESET = 8'h00;
    // ----------------------------------------------------------------
    // fields of pin_function_misc
    // ----------------------------------------------------------------
    localparam int unsigned POS_READBACK_SEL = 3;
    localparam int unsigned POS_RATE_DOUBLE = 4;
    localparam int unsigned POS_RATE_HALF = 5;
    localparam int unsigned POS_SDA_DELAY_LO = 6;
    // ----------------------------------------------------------------
    // group bit positions in pull-up and drive registers
    // ----------------------------------------------------------------
    localparam int unsigned GRP_P0_LOW = 0;
    localparam int unsigned GRP_P0_HIGH = 1;
    localparam int unsigned GRP_P1_LOW = 2;
    localparam int unsigned GRP_P1_HIGH = 3;
    localparam int unsigned GRP_P3_LOW = 6;
    localparam int unsigned GRP_P3_HIGH = 7;
    localparam int unsigned GRP_P4 = 1;
    localparam int unsigned GRP_P6 = 5;
    localparam int unsigned GRP_P7 = 7;
    localparam int unsigned GRP_P8 = 0;
    // ----------------------------------------------------------------
    // sda delay in peripheral clock cycles per code
    // ----------------------------------------------------------------
    localparam int unsigned SDA_DLY_CYC0 = 3;
    localparam int unsigned SDA_DLY_CYC1 = 11;
    localparam int unsigned SDA_DLY_CYC2 = 19;
    localparam logic SDA_IDLE = 1'b1;         // released bus level
endpackage

//--- rtl/ppcb_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module ppcb_sync #(
    parameter int unsigned W = 1              // vector width
) (
    input  wire logic         clk,            // system clock
    input  wire logic         rst,            // sync reset, high
    input  wire logic         ce,             // clock enable
    input  wire logic [W-1:0] d,              // asynchronous input
    output logic      [W-1:0] q               // synchronised output
);
    // ----------------------------------------------------------------
    // stages
    // ----------------------------------------------------------------
    logic [W-1:0] meta_q;                     // first stage, read by q only

    // first stage samples the pins
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= '0;
        end else if (ce) begin
            meta_q <= d;
        end
    end

    // second stage is the only reader of the first
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else if (ce) begin
            q <= meta_q;
        end
    end
endmodule
`default_nettype wire

//--- rtl/ppcb_sda_delay.sv
// selectable digital delay line for the sda input
`timescale 1ns/100ps
`default_nettype none
module ppcb_sda_delay
    import ppcb_pkg::*;
(
    input  wire logic       clk,              // peripheral clock
    input  wire logic       rst,              // sync reset, high
    input  wire logic       ce,               // clock enable
    input  wire logic [1:0] delaySel,         // delay code
    input  wire logic       sdaIn,            // synchronised sda
    output logic            sdaOut            // delayed sda, registered
);
    // ----------------------------------------------------------------
    // shift line, the output flop adds the last cycle
    // ----------------------------------------------------------------
    logic [SDA_DLY_CYC2-2:0] line_q;          // taps of the line

    // shift every enabled cycle, idle level after reset
    always_ff @(posedge clk) begin
        if (rst) begin
            line_q <= {(SDA_DLY_CYC2-1){SDA_IDLE}};
        end else if (ce) begin
            line_q <= {line_q[SDA_DLY_CYC2-3:0], sdaIn};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sdaOut <= SDA_IDLE;
        end else if (ce) begin
            unique case (delaySel)
                2'b01:   sdaOut <= line_q[SDA_DLY_CYC1-2];
                2'b10:   sdaOut <= line_q[SDA_DLY_CYC2-2];
                // forbidden code falls back to the shortest delay
                default: sdaOut <= line_q[SDA_DLY_CYC0-2];
            endcase
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [2:0] ceRun_q;                      // helper: recent enables

    always_ff @(posedge clk) begin
        ceRun_q <= rst ? 3'h0 : {ceRun_q[1:0], ce};
    end

    AST_SDA_DLY3: assert property (@(posedge clk) disable iff (rst)
        ceRun_q == 3'h7 && $past(ce, 3) && $past(delaySel) == 2'b00
        && $past(delaySel, 2) == 2'b00 && $past(rst, 3) == 1'b0
        |-> sdaOut == $past(sdaIn, 3))
        else $error("sda delay code 0 is not three cycles");
endmodule
`default_nettype wire

//--- rtl/ppcb_top.sv
// port pin configuration bank with apb register slave
//
// Register access over APB was decided locally.
`timescale 1ns/100ps
`default_nettype none
module ppcb_top
    import ppcb_pkg::*;
(
    input  wire logic        clk,             // system clock, 100 MHz
    input  wire logic        rst,             // sync reset, high
    input  wire logic        ce,              // clock enable
    input  wire logic        psel,            // apb select
    input  wire logic        penable,         // apb enable
    input  wire logic        pwrite,          // apb direction
    input  wire logic [11:0] paddr,           // apb byte address
    input  wire logic [31:0] pwdata,          // apb write data
    input  wire logic [3:0]  pstrb,           // apb byte strobes
    output logic      [31:0] prdata,          // apb read data
    output logic             pready,          // apb ready
    output logic             pslverr,         // apb error
    input  wire logic [55:0] pinIn,           // pin levels, asynchronous
    input  wire logic [55:0] portDir,         // direction, 1 = output
    input  wire logic [55:0] portLatch,       // output latch values
    input  wire logic        sdaIn,           // sda pin level
    output logic      [55:0] portRead,        // port read value
    output logic      [55:0] pullupEn,        // pull-up on per pin
    output logic      [55:0] driveHigh,       // high drive per pin
    output logic             i2cRateDouble,   // i2c rate doubled
    output logic             i2cRateHalf,     // i2c rate halved
    output logic             sdaDelayed       // delayed sda
);
    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------

    // register slot from byte address; slot 8 flags an unmapped word
    function automatic logic [3:0] regDecode(input logic [11:0] a);
        logic [3:0] r;
        r = 4'h8;
        for (int k = 0; k < NREG; k++) begin
            if (a == {REG_IDX[k], 2'b00}) begin
                r = 4'(k);
            end
        end
        return r;
    endfunction

    // group select bit of a pin, shared by pull-up and drive maps
    function automatic logic groupSel(
        input int unsigned s,
        input int unsigned b,
        input logic [7:0] r0,
        input logic [7:0] r1,
        input logic [7:0] r2
    );
        logic g;
        g = 1'b0;
        unique case (s)
            SLOT_P0: begin
                if (b <= 3) begin
                    g = r0[GRP_P0_LOW];
                end else if (b == 4 || b == 7) begin
                    g = r0[GRP_P0_HIGH];
                end
            end
            SLOT_P1: begin
                g = (b <= 3) ? r0[GRP_P1_LOW] : r0[GRP_P1_HIGH];
            end
            SLOT_P3: begin
                if (b == 0 || b == 3) begin
                    g = r0[GRP_P3_LOW];
                end else if (b == 4 || b == 5 || b == 7) begin
                    g = r0[GRP_P3_HIGH];
                end
            end
            SLOT_P4: g = (b >= 5) ? r1[GRP_P4] : 1'b0;
            SLOT_P6: g = (b >= 5) ? r1[GRP_P6] : 1'b0;
            SLOT_P7: g = (b >= 6) ? r1[GRP_P7] : 1'b0;
            SLOT_P8: g = (b >= 1 && b <= 3) ? r2[GRP_P8] : 1'b0;
            default: g = 1'b0;
        endcase
        return g;
    endfunction

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [7:0]  regFile_q [NREG];            // the eight registers
    logic [3:0]  setupSlot;                   // slot during setup
    logic [3:0]  accSlot;                     // slot during access
    logic        setupPhase;                  // apb setup cycle
    logic        wrTake;                      // write commits now
    logic [55:0] pinSync;                     // synchronised pins
    logic        sdaSync;                     // synchronised sda
    logic [55:0] pullD;                       // next pull-up vector
    logic [55:0] driveD;                      // next drive vector
    logic        readbackSel;                 // readback select bit
    logic        rateDbl;                     // double-rate bit
    logic        rateHalf;                    // half-rate bit
    logic [1:0]  sdaDelaySel;                 // sda delay code

    assign setupPhase = psel & ~penable;
    assign setupSlot  = regDecode(paddr);
    assign accSlot    = regDecode(paddr);
    // commit only at the edge where the master sees pready
    assign wrTake = psel & penable & pwrite & pready & ~accSlot[3] & pstrb[0];

    assign readbackSel = regFile_q[R_MISC][POS_READBACK_SEL];
    assign rateDbl     = regFile_q[R_MISC][POS_RATE_DOUBLE];
    assign rateHalf    = regFile_q[R_MISC][POS_RATE_HALF];
    assign sdaDelaySel = regFile_q[R_MISC][POS_SDA_DELAY_LO +: 2];

    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------

    // ready goes up for the access cycle after every setup
    always_ff @(posedge clk) begin
        if (rst) begin
            pready <= 1'b0;
        end else if (ce) begin
            pready <= setupPhase;
        end
    end

    // unmapped addresses answer with an error, no state change
    always_ff @(posedge clk) begin
        if (rst) begin
            pslverr <= 1'b0;
        end else if (ce) begin
            pslverr <= setupPhase & setupSlot[3];
        end
    end

    // upper bits and unassigned bits read zero
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= '0;
        end else if (ce && setupPhase) begin
            prdata <= setupSlot[3] ? 32'h0000_0000
                                   : {24'h00_0000, regFile_q[setupSlot[2:0]]};
        end
    end

    // writes land only on implemented bits
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int k = 0; k < NREG; k++) begin
                regFile_q[k] <= REG_RESET;
            end
        end else if (ce && wrTake) begin
            regFile_q[accSlot[2:0]] <= pwdata[7:0] & REG_MASK[accSlot[2:0]];
        end
    end

    // ----------------------------------------------------------------
    // pin input synchronisation
    // ----------------------------------------------------------------
    // pins and sda share one synchroniser so they stay aligned
    ppcb_sync #(
        .W (NPIN + 1)
    ) u_sync (
        .clk (clk),
        .rst (rst),
        .ce  (ce),
        .d   ({sdaIn, pinIn}),
        .q   ({sdaSync, pinSync})
    );

    // ----------------------------------------------------------------
    // port readback
    // ----------------------------------------------------------------

    // one select bit steers every slot
    // select set reads pins for all
    always_ff @(posedge clk) begin
        if (rst) begin
            portRead <= '0;
        end else if (ce) begin
            if (readbackSel) begin
                portRead <= pinSync;
            end else begin
                portRead <= (portDir & portLatch) | (~portDir & pinSync);
            end
        end
    end

    // ----------------------------------------------------------------
    // i2c rate modifiers
    // ----------------------------------------------------------------

    // double rate, dropped if half also set
    always_ff @(posedge clk) begin
        if (rst) begin
            i2cRateDouble <= 1'b0;
        end else if (ce) begin
            i2cRateDouble <= rateDbl & ~rateHalf;
        end
    end

    // half rate; both set falls back to nominal
    always_ff @(posedge clk) begin
        if (rst) begin
            i2cRateHalf <= 1'b0;
        end else if (ce) begin
            i2cRateHalf <= rateHalf & ~rateDbl;
        end
    end

    // ----------------------------------------------------------------
    // sda delay line
    // ----------------------------------------------------------------
    // delay code from the misc register
    ppcb_sda_delay u_sdaDelay (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .delaySel (sdaDelaySel),
        .sdaIn    (sdaSync),
        .sdaOut   (sdaDelayed)
    );

    // ----------------------------------------------------------------
    // pull-up and drive maps
    // ----------------------------------------------------------------

    // group maps of the pull-up and drive registers
    always_comb begin
        pullD  = '0;
        driveD = '0;
        for (int s = 0; s < NSLOT; s++) begin
            for (int b = 0; b < 8; b++) begin
                pullD[s*8+b] = groupSel(s, b, regFile_q[R_PULLUP_CONTROL_0],
                    regFile_q[R_PULLUP_CONTROL_1], regFile_q[R_PULLUP_CONTROL_2]);
                driveD[s*8+b] = groupSel(s, b, regFile_q[R_DRV0],
                    regFile_q[R_DRV1], regFile_q[R_DRV2]);
            end
        end
        // port 1 has one drive bit per pin
        driveD[SLOT_P1*8 +: 8] = regFile_q[R_P1DRV];
    end

    // pull-up only where direction is input
    always_ff @(posedge clk) begin
        if (rst) begin
            pullupEn <= '0;
        end else if (ce) begin
            pullupEn <= pullD & ~portDir;
        end
    end

    // drive only where direction is output
    always_ff @(posedge clk) begin
        if (rst) begin
            driveHigh <= '0;
        end else if (ce) begin
            driveHigh <= driveD & portDir;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic pastOk_q;                           // helper: last edge live

    always_ff @(posedge clk) begin
        pastOk_q <= ~rst & ce;
    end

    default clocking ast_cb @(posedge clk);
    endclocking
    default disable iff (rst);

    AST_RB_LATCH: assert property (
        pastOk_q && !$past(readbackSel) |->
        portRead == (($past(portDir) & $past(portLatch))
                   | (~$past(portDir) & $past(pinSync))))
        else $error("readback does not follow direction");

    AST_RB_PIN: assert property (
        pastOk_q && $past(readbackSel) |-> portRead == $past(pinSync))
        else $error("readback select does not read pins");

    AST_RATE_DBL: assert property (
        pastOk_q && $past(rateDbl) && !$past(rateHalf) |-> i2cRateDouble)
        else $error("double rate not applied");

    AST_RATE_HALF: assert property (
        pastOk_q |-> i2cRateHalf == ($past(rateHalf) && !$past(rateDbl)))
        else $error("half rate wrong");

    AST_PULL_DIR: assert property (
        pastOk_q |-> (pullupEn & $past(portDir)) == 56'h00_0000_0000_0000)
        else $error("pull-up on an output pin");

    AST_PULL_P0: assert property (
        pastOk_q && $past(regFile_q[R_PULLUP_CONTROL_0][GRP_P0_HIGH]) && !$past(portDir[7])
        |-> pullupEn[7] && !pullupEn[5])
        else $error("pull-up group for port 0 high wrong");

    AST_PULL_P8: assert property (
        pastOk_q && $past(regFile_q[R_PULLUP_CONTROL_2][GRP_P8]) && !$past(portDir[49])
        |-> pullupEn[49] && !pullupEn[48])
        else $error("pull-up group for port 8 wrong");

    AST_DRV_P1: assert property (
        pastOk_q |-> driveHigh[15:8] ==
        ($past(regFile_q[R_P1DRV]) & $past(portDir[15:8])))
        else $error("port 1 drive bits wrong");

    AST_DRV_IN: assert property (
        pastOk_q |-> (driveHigh & ~$past(portDir)) == 56'h00_0000_0000_0000)
        else $error("drive select on an input pin");

    AST_DRV_P3: assert property (
        pastOk_q && $past(regFile_q[R_DRV0][GRP_P3_HIGH]) && $past(portDir[23])
        |-> driveHigh[23] && !driveHigh[22])
        else $error("drive group for port 3 high wrong");

    AST_DRV_P7: assert property (
        pastOk_q && $past(regFile_q[R_DRV1][GRP_P7]) && $past(portDir[46])
        |-> driveHigh[46] && !driveHigh[45])
        else $error("drive group for port 7 wrong");

    AST_RSVD_RD: assert property (
        pready && !pslverr && !pwrite |-> prdata[31:8] == 24'h00_0000
        && (prdata[7:0] & ~REG_MASK[$past(setupSlot[2:0])]) == 8'h00)
        else $error("unassigned bits read nonzero");

    AST_RST_CLR: assert property (
        $past(rst) |-> regFile_q[R_MISC] == REG_RESET && !pready
        && regFile_q[R_DRV2] == REG_RESET && regFile_q[R_P1DRV] == REG_RESET)
        else $error("registers not cleared by reset");
endmodule
`default_nettype wire

//--- sim/ppcb_tb_top.sv
// self-checking bench for the port pin configuration bank
`timescale 1ns/100ps
`default_nettype none
module ppcb_tb_top
    import ppcb_pkg::*;
;
    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    localparam logic [55:0] GRP = 56'h0E_C0E0_E0B9_FF9F; // pins in any group
    localparam logic [55:0] DIR = 56'h55_5555_5555_5555; // even pins output
    localparam logic [55:0] PIN = 56'h12_3456_789A_BCDE; // pin levels
    localparam logic [55:0] LAT = 56'hED_CBA9_8765_4321; // latch values
    logic        clk;         // system clock
    logic        rst;         // sync reset
    logic        psel;        // apb select
    logic        penable;     // apb enable
    logic        pwrite;      // apb direction
    logic [11:0] paddr;       // apb address
    logic [31:0] pwdata;      // apb write data
    logic [31:0] prdata;      // apb read data
    logic        pready;      // apb ready
    logic        pslverr;     // apb error
    logic [55:0] pinIn;       // pin levels
    logic [55:0] portDir;     // directions
    logic [55:0] portLatch;   // latches
    logic        sdaIn;       // sda pin
    logic [55:0] portRead;    // read value
    logic [55:0] pullupEn;    // pull-ups
    logic [55:0] driveHigh;   // drive selects
    logic        rateDbl;     // double rate
    logic        rateHalf;    // half rate
    logic        sdaDelayed;  // delayed sda
    logic [31:0] rdat;        // last read data
    logic        rerr;        // last error flag
    int          err_total;   // mismatches
    int          checks_done; // comparisons

    ppcb_top ppcb_top_inst (.clk(clk), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pinIn(pinIn), .portDir(portDir),
        .portLatch(portLatch), .sdaIn(sdaIn), .portRead(portRead), .pullupEn(pullupEn),
        .driveHigh(driveHigh), .i2cRateDouble(rateDbl), .i2cRateHalf(rateHalf),
        .sdaDelayed(sdaDelayed));

    // clock, 10 ns period
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    // verdict and end of run, reached from every path
    task automatic stop_test();
        if (err_total == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // compare one value, case equality so unknowns fail
    task automatic chk(input string nm, input logic [55:0] exp, input logic [55:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one apb transfer; request held until pready seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h00_0000, wd};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        // bound used up: slave never answered
        if (pready !== 1'b1) begin
            err_total++;
            stop_test();
        end
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        // outputs launched by the write edge settle one edge later
        @(posedge clk);
    endtask

    // register access by index
    task automatic wr(input int i, input logic [7:0] d);
        apb(1'b1, {REG_IDX[i], 2'b00}, d);
    endtask

    task automatic rdchk(input int i, input logic [7:0] exp);
        apb(1'b0, {REG_IDX[i], 2'b00}, 8'h00);
        chk("register", 56'(exp), 56'(rdat));
    endtask

    // drive sda low and count edges until the delayed copy follows
    task automatic sdachk(input logic [1:0] code, input int n);
        int c;
        c = 0;
        wr(R_MISC, {code, 6'h00});
        sdaIn <= 1'b0;
        do begin
            @(posedge clk);
            c++;
            #1;
        end while (sdaDelayed !== 1'b0 && c < 40);
        chk("sda delay", 56'(n), 56'(c));
        // release sda on an edge, never off it
        @(posedge clk);
        sdaIn <= 1'b1;
        repeat (30) @(posedge clk);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {err_total, checks_done} = '0;
        {rst, sdaIn} = 2'b11;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {pinIn, portDir, portLatch} = {PIN, DIR, LAT};
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < NREG; i++) rdchk(i, REG_RESET);
        for (int i = 0; i < NREG; i++) begin
            wr(i, 8'hFF);
            rdchk(i, REG_MASK[i]);
        end
        // both rate bits set falls back to nominal rate
        chk("rate pair", 56'h0, 56'({rateDbl, rateHalf}));
        chk("read pins", PIN, portRead);
        chk("pullup", GRP & ~DIR, pullupEn);
        chk("drive", GRP & DIR, driveHigh);
        wr(R_MISC, 8'h10);
        chk("rate dbl", 56'h2, 56'({rateDbl, rateHalf}));
        wr(R_MISC, 8'h20);
        chk("rate half", 56'h1, 56'({rateDbl, rateHalf}));
        wr(R_MISC, 8'h00);
        chk("read mix", (DIR & LAT) | (~DIR & PIN), portRead);
        portDir <= '0;
        repeat (2) @(posedge clk);
        chk("pullup all", GRP, pullupEn);
        chk("drive none", 56'h0, driveHigh);
        portDir <= '1;
        wr(R_P1DRV, 8'h0F);
        chk("pullup none", 56'h0, pullupEn);
        chk("drive p1", GRP & ~56'h00_0000_0000_F000, driveHigh);
        chk("read latch", LAT, portRead);
        apb(1'b0, 12'h000, 8'h00);
        chk("unmapped", 56'h1, 56'({rdat, rerr}));
        sdachk(2'b00, 5);
        sdachk(2'b01, 13);
        sdachk(2'b10, 21);
        stop_test();
    end
endmodule
`default_nettype wire
